// file: pic_ctrl.sv
// Purpose: Sampled PI loop controller with APB register access
// Assumes: Inputs synchronous to pclk; 200 MHz clock
// Notes:   Output in units of 0..1000, gains in hundredths
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl
   import pic_pkg::*;
#(
   parameter longint SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control inputs
   input wire logic auto_manual_select,
   input wire logic output_clear,
   input wire logic signed [15:0] process_value_in,
   // Actuator output
   output logic [10:0] manipulated_output
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic signed [31:0] clamp_s(input logic signed [31:0] v,
                                                  input logic signed [31:0] lo,
                                                  input logic signed [31:0] hi);
      if (v > hi) begin
         clamp_s = hi;
      end else if (v < lo) begin
         clamp_s = lo;
      end else begin
         clamp_s = v;
      end
   endfunction

   function automatic logic [10:0] sat_out(input logic signed [31:0] v);
      sat_out = 11'(clamp_s(v, OUT_MIN, OUT_MAX));
   endfunction

   function automatic logic signed [31:0] sext(input logic [15:0] v);
      sext = {{16{v[15]}}, v};
   endfunction

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   pic_ctrl_t ctrl_q;
   logic signed [15:0] setpoint_q;
   logic signed [15:0] pv_low_q;
   logic signed [15:0] pv_high_q;
   logic signed [15:0] pv_gain_q;
   logic signed [15:0] pv_offset_q;
   logic [10:0] manual_q;
   logic [13:0] loop_gain_q;
   logic [12:0] int_time_q;
   logic dir_act_q;
   logic auto_prev_q;
   logic [31:0] tick_cnt_q;
   logic tick_q;
   pic_state_t state_q;
   logic signed [31:0] prod_q;
   logic signed [31:0] pv_eff_q;
   logic signed [31:0] kce_q;
   logic err_zero_q;
   logic signed [31:0] i_term_q;
   logic [10:0] sum_q;
   logic [10:0] out_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   pic_tune_t tune;
   logic signed [31:0] err;
   logic auto_on;
   logic wr_en;
   logic addr_ok;
   logic [31:0] rd_data;
   logic div_done;
   logic [31:0] div_quo;
   logic div_start;
   logic [31:0] kce_mag;
   logic signed [31:0] sum_next;
   logic signed [31:0] out_next;

   // Active tuning: preset or software values
   assign tune = pic_preset(ctrl_q.preset, '{kc: loop_gain_q, ti: int_time_q,
                                             dir_minus: ctrl_q.dir_minus});
   // Automatic mode only when not cleared
   assign auto_on = auto_manual_select && !output_clear;

   // ----------------------------------------------------------------
   // APB access
   // ----------------------------------------------------------------
   // Address decode
   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h0;
      case (paddr)
         OFS_CTRL: rd_data = {25'h0, ctrl_q};
         OFS_SETPOINT: rd_data = {16'h0, setpoint_q};
         OFS_PV_LOW: rd_data = {16'h0, pv_low_q};
         OFS_PV_HIGH: rd_data = {16'h0, pv_high_q};
         OFS_PV_GAIN: rd_data = {16'h0, pv_gain_q};
         OFS_PV_OFFSET: rd_data = {16'h0, pv_offset_q};
         OFS_MANUAL: rd_data = {21'h0, manual_q};
         OFS_LOOP_GAIN: rd_data = {18'h0, loop_gain_q};
         OFS_INT_TIME: rd_data = {19'h0, int_time_q};
         OFS_STATUS: rd_data = {13'h0, dir_act_q, auto_on, output_clear, 5'h0, out_q};
         OFS_PV_EFF: rd_data = {16'h0, pv_eff_q[15:0]};
         OFS_INT_SUM: rd_data = {21'h0, sum_q};
         default: addr_ok = 1'b0;
      endcase
   end

   // Write takes effect at the completing access edge
   assign wr_en = psel && penable && pready_q && pwrite && addr_ok;

   // Answer one cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && !penable;
         if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h0 : rd_data;
            pslverr_q <= !addr_ok;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // Software registers, clamped to their ranges on write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         setpoint_q <= 16'sh0000;
         pv_low_q <= PV_LOW_RST;
         pv_high_q <= PV_HIGH_RST;
         pv_gain_q <= GAIN_RST;
         pv_offset_q <= 16'sh0000;
         manual_q <= 11'h0;
         loop_gain_q <= 14'h0064;
         int_time_q <= TI_MAX;
      end else if (wr_en) begin
         case (paddr)
            OFS_CTRL: ctrl_q <= pic_ctrl_t'(pwdata[6:0]);
            OFS_SETPOINT: setpoint_q <= 16'(clamp_s(sext(pwdata[15:0]), PV_MIN, PV_MAX));
            OFS_PV_LOW: pv_low_q <= 16'(clamp_s(sext(pwdata[15:0]), PV_MIN, PV_MAX));
            OFS_PV_HIGH: pv_high_q <= 16'(clamp_s(sext(pwdata[15:0]), PV_MIN, PV_MAX));
            OFS_PV_GAIN: pv_gain_q <= 16'(clamp_s(sext(pwdata[15:0]), GAIN_MIN, GAIN_MAX));
            OFS_PV_OFFSET: pv_offset_q <= 16'(clamp_s(sext(pwdata[15:0]), OFFS_MIN, OFFS_MAX));
            OFS_MANUAL: manual_q <= sat_out($signed({16'h0, pwdata[15:0]}));
            OFS_LOOP_GAIN: loop_gain_q <= (pwdata[15:0] > 16'(KC_MAX)) ? KC_MAX : pwdata[13:0];
            OFS_INT_TIME: begin
               if (pwdata[15:0] > 16'(TI_MAX)) begin
                  int_time_q <= TI_MAX;
               end else if (pwdata[15:0] < 16'(TI_MIN)) begin
                  int_time_q <= TI_MIN;
               end else begin
                  int_time_q <= pwdata[12:0];
               end
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sample timing
   // ----------------------------------------------------------------
   // Fixed sample tick while the function runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (!ctrl_q.run) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 32'(SAMPLE_CYCLES - 64'h1)) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   // Direction only follows settings while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_act_q <= 1'b0;
      end else if (!ctrl_q.run) begin
         dir_act_q <= tune.dir_minus;
      end
   end

   // ----------------------------------------------------------------
   // Computation sequence
   // ----------------------------------------------------------------
   // Error sign follows the latched direction
   assign err = dir_act_q ? (pv_eff_q - sext(setpoint_q))
                          : (sext(setpoint_q) - pv_eff_q);
   assign kce_mag = kce_q[31] ? 32'(-kce_q) : 32'(kce_q);
   assign div_start = (state_q == ST_DIV) && (tune.ti != TI_MAX) && !err_zero_q;

   pic_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .dividend(kce_mag),
      .divisor(I_DEN * {19'h0, tune.ti}),
      .done(div_done),
      .quotient(div_quo)
   );

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         prod_q <= 32'sh0;
         pv_eff_q <= 32'sh0;
         kce_q <= 32'sh0;
         err_zero_q <= 1'b0;
         i_term_q <= 32'sh0;
      end else if (!auto_on || !ctrl_q.run) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (tick_q) begin
                  state_q <= ST_SCALE;
               end
            end
            ST_SCALE: begin
               prod_q <= process_value_in * pv_gain_q;
               state_q <= ST_CLAMP;
            end
            ST_CLAMP: begin
               pv_eff_q <= clamp_s(prod_q / HUNDRED + sext(pv_offset_q),
                                   sext(pv_low_q), sext(pv_high_q));
               state_q <= ST_PROD;
            end
            ST_PROD: begin
               kce_q <= err * $signed({18'h0, tune.kc});
               err_zero_q <= (err == 32'sh0);
               state_q <= ST_DIV;
            end
            ST_DIV: begin
               i_term_q <= 32'sh0;
               if (div_start) begin
                  state_q <= ST_WAIT;
               end else begin
                  state_q <= ST_UPD;
               end
            end
            ST_WAIT: begin
               if (div_done) begin
                  i_term_q <= kce_q[31] ? -$signed(div_quo) : $signed(div_quo);
                  state_q <= ST_UPD;
               end
            end
            ST_UPD: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // PI law with saturated sum
   always_comb begin
      sum_next = $signed({21'h0, sat_out($signed({21'h0, sum_q}) + i_term_q)});
      out_next = kce_q / HUNDRED + sum_next;
   end

   // ----------------------------------------------------------------
   // Output and integral sum
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= 11'h0;
         sum_q <= 11'h0;
         auto_prev_q <= 1'b0;
      end else if (output_clear) begin
         out_q <= 11'h0;
         sum_q <= 11'h0;
         auto_prev_q <= auto_manual_select;
      end else begin
         auto_prev_q <= auto_manual_select;
         if (!auto_manual_select) begin
            out_q <= manual_q;
         end else if (!auto_prev_q) begin
            sum_q <= manual_q;
         end else if (state_q == ST_UPD && !err_zero_q) begin
            sum_q <= 11'(sum_next);
            out_q <= sat_out(out_next);
         end
      end
   end

   // Outputs straight from flip-flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign manipulated_output = out_q;

endmodule // pic_ctrl
`default_nettype wire

// file: pic_pkg.sv
// Purpose: Shared constants, types and helpers of the PI loop controller
// Assumes: 32-bit APB data, 200 MHz pclk
// Notes:   Values in hundredths where a fraction is needed
package pic_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SETPOINT = 8'h04;
   localparam logic [7:0] OFS_PV_LOW = 8'h08;
   localparam logic [7:0] OFS_PV_HIGH = 8'h0c;
   localparam logic [7:0] OFS_PV_GAIN = 8'h10;
   localparam logic [7:0] OFS_PV_OFFSET = 8'h14;
   localparam logic [7:0] OFS_MANUAL = 8'h18;
   localparam logic [7:0] OFS_LOOP_GAIN = 8'h1c;
   localparam logic [7:0] OFS_INT_TIME = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_PV_EFF = 8'h28;
   localparam logic [7:0] OFS_INT_SUM = 8'h2c;

   // ----------------------------------------------------------------
   // Value ranges and reset values
   // ----------------------------------------------------------------
   localparam logic signed [31:0] PV_MIN = 32'shffffd8f0;   // -10000
   localparam logic signed [31:0] PV_MAX = 32'sh00004e20;   // +20000
   localparam logic signed [31:0] GAIN_MIN = 32'shfffffc18; // -10.00
   localparam logic signed [31:0] GAIN_MAX = 32'sh000003e8; // +10.00
   localparam logic signed [31:0] OFFS_MIN = 32'shffffd8f0; // -10000
   localparam logic signed [31:0] OFFS_MAX = 32'sh00002710; // +10000
   localparam logic signed [31:0] OUT_MIN = 32'sh00000000;
   localparam logic signed [31:0] OUT_MAX = 32'sh000003e8;  // 1000
   localparam logic [13:0] KC_MAX = 14'h270f;              // 99.99
   localparam logic [12:0] TI_MIN = 13'h0001;              // 1 s
   localparam logic [12:0] TI_MAX = 13'h176f;              // 99:59 min
   localparam logic signed [15:0] GAIN_RST = 16'sh0064;    // 1.00
   localparam logic signed [15:0] PV_HIGH_RST = 16'sh4e20;
   localparam logic signed [15:0] PV_LOW_RST = 16'shd8f0;
   localparam logic signed [31:0] HUNDRED = 32'sh00000064;  // Fixed point scale

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint SAMPLE_TIME_MS = 64'h1f4;             // 500 ms
   localparam longint CLK_PERIOD_PS = 64'h1388;             // 5 ns
   localparam longint SAMPLE_CYCLES_DEF = SAMPLE_TIME_MS * 64'h3b9aca00 / CLK_PERIOD_PS;
   // Integral divisor per second of integral time: 100 (scale) / Ts
   localparam logic [31:0] I_DEN = 32'(64'h64 * 64'h3e8 / SAMPLE_TIME_MS);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] decimals;  // Bits 6:5
      logic [2:0] preset;    // Bits 4:2
      logic run;             // Bit 1
      logic dir_minus;       // Bit 0
   } pic_ctrl_t;

   typedef struct packed {
      logic [13:0] kc;
      logic [12:0] ti;
      logic dir_minus;
   } pic_tune_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SCALE = 3'b001,
      ST_CLAMP = 3'b010,
      ST_PROD = 3'b011,
      ST_DIV = 3'b100,
      ST_WAIT = 3'b101,
      ST_UPD = 3'b110
   } pic_state_t;

   // Preset tuning triples; select 0 uses the software values
   function automatic pic_tune_t pic_preset(input logic [2:0] sel, input pic_tune_t custom);
      case (sel)
         3'h1: pic_preset = '{kc: 14'h0032, ti: 13'h001e, dir_minus: 1'b0};
         3'h2: pic_preset = '{kc: 14'h0064, ti: 13'h0078, dir_minus: 1'b0};
         3'h3: pic_preset = '{kc: 14'h012c, ti: 13'h0005, dir_minus: 1'b0};
         3'h4: pic_preset = '{kc: 14'h0078, ti: 13'h000c, dir_minus: 1'b0};
         3'h5: pic_preset = '{kc: 14'h0064, ti: 13'h176f, dir_minus: 1'b0};
         3'h6: pic_preset = '{kc: 14'h0046, ti: 13'h0014, dir_minus: 1'b0};
         default: pic_preset = custom;
      endcase
   endfunction

endpackage

// file: pic_div.sv
// Purpose: Iterative unsigned divider for the integral term
// Assumes: Divisor nonzero; start only while idle
// Notes:   One quotient bit per cycle, done pulse after 32 steps
`timescale 1ns/1ps
`default_nettype none
module pic_div
   import pic_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request
   input wire logic start,
   input wire logic [31:0] dividend,
   input wire logic [31:0] divisor,
   // Answer
   output logic done,
   output logic [31:0] quotient
);

   logic [32:0] rem_q;
   logic [31:0] quo_q;
   logic [31:0] dsr_q;
   logic [5:0] cnt_q;
   logic busy_q;
   logic [32:0] trial;

   // Trial subtraction of the shifted remainder
   assign trial = {rem_q[31:0], quo_q[31]} - {1'b0, dsr_q};

   // ----------------------------------------------------------------
   // Restoring division
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_q <= 33'h0;
         quo_q <= 32'h0;
         dsr_q <= 32'h0;
         cnt_q <= 6'h0;
         busy_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy_q) begin
            rem_q <= 33'h0;
            quo_q <= dividend;
            dsr_q <= divisor;
            cnt_q <= 6'h20;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (!trial[32]) begin
               rem_q <= trial;
               quo_q <= {quo_q[30:0], 1'b1};
            end else begin
               rem_q <= {rem_q[31:0], quo_q[31]};
               quo_q <= {quo_q[30:0], 1'b0};
            end
            cnt_q <= cnt_q - 6'h1;
            if (cnt_q == 6'h1) begin
               busy_q <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   assign quotient = quo_q;

endmodule // pic_div
`default_nettype wire

// file: pic_ctrl_chk.sv
// Purpose: Port assertions of the PI loop controller
// Assumes: Bound to pic_ctrl, one clock domain
// Notes:   Sees only top ports
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_chk
   import pic_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Control
   input wire logic auto_manual_select,
   input wire logic output_clear,
   input wire logic [10:0] manipulated_output
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_out_range: assert property (manipulated_output <= 11'h3e8)
      else $error("output above 1000");
   chk_clear_zero: assert property (output_clear |=> manipulated_output == 11'h000)
      else $error("output not zero under clear");
   chk_manual_write: assert property (psel && penable && pready && pwrite && paddr == OFS_MANUAL
      && pwdata <= 32'h3e8 && !auto_manual_select && !output_clear ##1 !auto_manual_select && !output_clear
      |=> manipulated_output == $past(pwdata[10:0], 2))
      else $error("manual value not on output");
   chk_auto_entry: assert property ($rose(auto_manual_select) && !output_clear && !$past(output_clear)
      |=> $stable(manipulated_output)[*2])
      else $error("output jumped on entering automatic");
   chk_sample_gap: assert property ($changed(manipulated_output) && auto_manual_select && !output_clear
      |=> (!auto_manual_select || output_clear || $stable(manipulated_output))[*8])
      else $error("output changed twice within a sample");
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_unmapped: assert property (psel && !penable && paddr > 8'h2c |=> pslverr && pready)
      else $error("no error for unmapped address");
   chk_err_mapped: assert property (psel && !penable && paddr <= 8'h2c && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("error on mapped address");
endmodule // pic_ctrl_chk

bind pic_ctrl pic_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .auto_manual_select(auto_manual_select), .output_clear(output_clear),
   .manipulated_output(manipulated_output));
`default_nettype wire

// file: pic_pv_src.sv
// Purpose: Process value source feeding the controller
// Assumes: Bench sets the level to present
// Notes:   Conversion adds one clock of delay
`timescale 1ns/1ps
`default_nettype none
module pic_pv_src (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Level from the bench
   input wire logic signed [15:0] pv_set,
   // Towards the controller
   output logic signed [15:0] process_value_in
);
   // Sensor conversion register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         process_value_in <= 16'sh0000;
      end else begin
         process_value_in <= pv_set;
      end
   end
endmodule // pic_pv_src
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench of the PI loop controller
// Assumes: Short sample period through SAMPLE_CYCLES
// Notes:   Each sample scenario restarts from the manual value 500
`timescale 1ns/1ps
`default_nettype none
module tb
   import pic_pkg::*;
;
   localparam longint SC = 200;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, erv;
   logic auto_manual_select = 1'b0, output_clear = 1'b0;
   logic signed [15:0] pv_set = 16'sh0000, process_value_in;
   logic [10:0] manipulated_output;
   int n_mismatch = 0, n_checks = 0, n;
   logic [39:0] rst_tbl [9] = '{{8'h00, 32'h0}, {8'h04, 32'h0}, {8'h08, 32'hd8f0}, {8'h0c, 32'h4e20},
      {8'h10, 32'h64}, {8'h14, 32'h0}, {8'h18, 32'h0}, {8'h1c, 32'h64}, {8'h20, 32'h176f}};
   logic [71:0] rng_tbl [8] = '{{8'h04, 32'h7530, 32'h4e20}, {8'h04, 32'hffffb1e0, 32'hd8f0},
      {8'h10, 32'hfffff830, 32'hfc18}, {8'h14, 32'h3a98, 32'h2710}, {8'h1c, 32'h2ee0, 32'h270f},
      {8'h20, 32'h0, 32'h1}, {8'h20, 32'h1b58, 32'h176f}, {8'h18, 32'h5dc, 32'h3e8}};

   // Clock, design and process value source
   always #2.5 pclk = ~pclk;
   pic_ctrl #(.SAMPLE_CYCLES(SC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .auto_manual_select(auto_manual_select), .output_clear(output_clear),
      .process_value_in(process_value_in), .manipulated_output(manipulated_output));
   pic_pv_src u_src (.pclk(pclk), .presetn(presetn), .pv_set(pv_set), .process_value_in(process_value_in));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until ready is sampled
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask

   // Enter automatic from manual, run one sample, compare output
   task automatic samp(input logic [15:0] pv, input logic [31:0] ctrl, input logic [10:0] e);
      auto_manual_select <= 1'b0;
      pv_set <= pv;
      apb(1'b1, OFS_CTRL, ctrl & 32'hfffffffd);
      repeat (4) @(posedge pclk);
      auto_manual_select <= 1'b1;
      apb(1'b1, OFS_CTRL, ctrl | 32'h2);
      repeat (SC + 100) @(posedge pclk);
      chk(32'(manipulated_output), 32'(e));
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(rst_tbl[i][39:32], rst_tbl[i][31:0]);
      end
      apb(1'b0, 8'h30, 32'h0);
      chk({rdv[30:0], erv}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, rng_tbl[i][71:64], rng_tbl[i][63:32]);
         rd(rng_tbl[i][71:64], rng_tbl[i][31:0]);
      end
      repeat (3) @(posedge pclk);
      chk(32'(manipulated_output), 32'h3e8);
      apb(1'b1, OFS_MANUAL, 32'h258);
      repeat (3) @(posedge pclk);
      chk(32'(manipulated_output), 32'h258);
      // Working set: setpoint 1000, manual 500, unity scaling, P only
      apb(1'b1, OFS_SETPOINT, 32'h3e8);
      apb(1'b1, OFS_MANUAL, 32'h1f4);
      apb(1'b1, OFS_PV_GAIN, 32'h64);
      apb(1'b1, OFS_PV_OFFSET, 32'h0);
      apb(1'b1, OFS_LOOP_GAIN, 32'h64);
      samp(16'h0384, 32'h0, 11'h258);
      rd(OFS_INT_SUM, 32'h1f4);
      apb(1'b1, OFS_CTRL, 32'h3);
      repeat (2 * SC) @(posedge pclk);
      chk(32'(manipulated_output), 32'h258);
      samp(16'h044c, 32'h0, 11'h190);
      samp(16'h03e8, 32'h0, 11'h1f4);
      samp(16'h044c, 32'h1, 11'h258);
      samp(16'h0384, 32'h1, 11'h190);
      samp(16'h0384, 32'h60, 11'h258);
      apb(1'b1, OFS_PV_GAIN, 32'hc8);
      apb(1'b1, OFS_PV_OFFSET, 32'hfffffd44);
      samp(16'h0384, 32'h0, 11'h190);
      rd(OFS_PV_EFF, 32'h44c);
      apb(1'b1, OFS_PV_GAIN, 32'h64);
      apb(1'b1, OFS_PV_OFFSET, 32'h0);
      apb(1'b1, OFS_PV_HIGH, 32'h41a);
      apb(1'b1, OFS_PV_LOW, 32'h3b6);
      samp(16'h1388, 32'h0, 11'h1c2);
      rd(OFS_PV_EFF, 32'h41a);
      samp(16'hf448, 32'h0, 11'h226);
      apb(1'b1, OFS_PV_HIGH, 32'h4e20);
      apb(1'b1, OFS_PV_LOW, 32'hffffd8f0);
      apb(1'b1, OFS_LOOP_GAIN, 32'h7d0);
      samp(16'h0384, 32'h0, 11'h3e8);
      samp(16'h044c, 32'h0, 11'h000);
      apb(1'b1, OFS_LOOP_GAIN, 32'h64);
      samp(16'h0384, 32'hc, 11'h33e);
      apb(1'b1, OFS_INT_TIME, 32'h1);
      samp(16'h0384, 32'h0, 11'h28a);
      rd(OFS_INT_SUM, 32'h226);
      // Spacing of two successive updates
      n = 0;
      while (manipulated_output === 11'h28a && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(manipulated_output), 32'h2bc);
      n = 0;
      while (manipulated_output === 11'h2bc && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      chk(n, 32'(SC));
      output_clear <= 1'b1;
      repeat (3) @(posedge pclk);
      auto_manual_select <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(manipulated_output), 32'h0);
      rd(OFS_INT_SUM, 32'h0);
      rd(OFS_STATUS, 32'h00010000);
      output_clear <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(manipulated_output), 32'h1f4);
      tally_and_finish();
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
